//--- verilog/cbpc_pkg.sv
`default_nettype none
package cbpc_pkg;
    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int COEF_W = 16;

    // ----------------------------------------
    // Offsets
    // ----------------------------------------
    localparam logic [6:0] OFF_PAGE_SELECTOR = 7'h00;
    localparam logic [6:0] OFF_BYPASS_SELECT = 7'h6c;
    localparam logic [6:0] OFF_DAC_CURRENT = 7'h6d;
    localparam logic [6:0] OFF_RSVD_TAIL_FIRST = 7'h6e;
    localparam logic [6:0] OFF_RSVD_TAIL_LAST = 7'h7f;
    localparam logic [6:0] OFF_N0_HIGH = 7'h01;
    localparam logic [6:0] OFF_N0_LOW = 7'h02;
    localparam logic [6:0] OFF_N1_HIGH = 7'h03;
    localparam logic [6:0] OFF_N1_LOW = 7'h04;
    localparam logic [6:0] OFF_N2_HIGH = 7'h05;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PAGE_BIT = 0;
    localparam int DAC_CUR_LSB = 6;
    localparam int BYP_R2_MINUS = 7;
    localparam int BYP_R2_PLUS = 6;
    localparam int BYP_R1_MINUS = 5;
    localparam int BYP_R1_PLUS = 4;
    localparam int BYP_L2_MINUS = 3;
    localparam int BYP_L2_PLUS = 2;
    localparam int BYP_L1_MINUS = 1;
    localparam int BYP_L1_PLUS = 0;

    // ----------------------------------------
    // Field codes and reset values
    // ----------------------------------------
    localparam logic [1:0] DAC_CUR_RESERVED = 2'h2;
    localparam logic PAGE_ZERO = 1'h0;
    localparam logic PAGE_ONE = 1'h1;
    localparam logic [7:0] RST_BYPASS = 8'h00;
    localparam logic [1:0] RST_DAC_CUR = 2'h0;
    localparam logic [7:0] RST_N0_HIGH = 8'h6b;
    localparam logic [7:0] RST_N0_LOW = 8'he3;
    localparam logic [7:0] RST_N1_HIGH = 8'h96;
    localparam logic [7:0] RST_N1_LOW = 8'h66;
    localparam logic [7:0] RST_N2_HIGH = 8'h67;
    localparam logic [7:0] RD_ZERO = 8'h00;
endpackage
`default_nettype wire

//--- verilog/cbpc_coef_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cbpc_coef_if;
    logic wr_high;
    logic wr_low;
    logic [7:0] wdata;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    logic signed [15:0] coef;

    modport bank (output wr_high, output wr_low, output wdata,
                  input high_byte, input low_byte, input coef);
    modport pair (input wr_high, input wr_low, input wdata,
                  output high_byte, output low_byte, output coef);
endinterface // cbpc_coef_if
`default_nettype wire

//--- verilog/cbpc_coef_pair.sv
`timescale 1ns/1ps
`default_nettype none
module cbpc_coef_pair
    import cbpc_pkg::*;
#(
    parameter logic [7:0] RST_HIGH = 8'h00,
    parameter logic [7:0] RST_LOW = 8'h00
)(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    cbpc_coef_if.pair cif
);
    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
        logic [15:0] coef;
    } cbpc_pair_t;

    cbpc_pair_t st;
    cbpc_pair_t next_st;

    // ----------------------------------------
    // Byte storage and applied coefficient
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        if (cif.wr_high)
        begin
            next_st.high_byte = cif.wdata;
        end
        // Datapath sees the pair only after the low byte lands
        if (cif.wr_low)
        begin
            next_st.low_byte = cif.wdata;
            next_st.coef = {next_st.high_byte, cif.wdata};
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            st <= '{high_byte: RST_HIGH, low_byte: RST_LOW,
                    coef: {RST_HIGH, RST_LOW}};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign cif.high_byte = st.high_byte;
    assign cif.low_byte = st.low_byte;
    assign cif.coef = signed'(st.coef);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence high_then_low_s;
        (cif.wr_high && !cif.wr_low) ##1 (cif.wr_low && !cif.wr_high);
    endsequence

    coef_pair_apply_a: assert property (
        high_then_low_s |=> cif.coef == {$past(cif.wdata, 2), $past(cif.wdata)})
        else $error("coefficient not applied from high then low pair");

    coef_half_hold_a: assert property (
        (cif.wr_high && !cif.wr_low) |=> $stable(cif.coef))
        else $error("coefficient changed on a high byte write");
endmodule // cbpc_coef_pair
`default_nettype wire

//--- verilog/cbpc_regs.sv
// Behaviour
// - D5/D4 bypass right first inputs to lineout
// - D3..D0 bypass left inputs to lineout
// - D7/D6 bypass right second inputs to lineout
// - DAC current code; reserved code never stored
// - Page zero 110..127 read zero, ignore writes
// - Register zero bit zero selects page
// - Page selector identical on both pages
// - Coefficient is signed sixteen-bit value; numerator two stores only its 8-bit high byte, output unsigned
// - Page one registers one..five hold coefficients
// - Coefficient bytes load documented reset values
`timescale 1ns/1ps
`default_nettype none
module cbpc_regs
    import cbpc_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic page_one_active_out,
    output logic right_second_input_minus_bypass_out,
    output logic right_second_input_plus_bypass_out,
    output logic right_first_input_minus_bypass_out,
    output logic right_first_input_plus_bypass_out,
    output logic left_second_input_minus_bypass_out,
    output logic left_second_input_plus_bypass_out,
    output logic left_first_input_minus_bypass_out,
    output logic left_first_input_plus_bypass_out,
    output logic [1:0] dac_current_out,
    output logic signed [COEF_W-1:0] fx_numerator_zero_out,
    output logic signed [COEF_W-1:0] fx_numerator_one_out,
    output logic [DATA_W-1:0] fx_numerator_two_high_out
);
    typedef struct packed {
        logic page;
        logic [7:0] bypass;
        logic [1:0] dac_cur;
        logic [7:0] n2_high;
        logic [7:0] rdata;
        logic rvalid;
    } cbpc_state_t;

    cbpc_state_t st;
    cbpc_state_t next_st;

    cbpc_coef_if n0_if();
    cbpc_coef_if n1_if();

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Register zero ignores the page so software can always get back
    function automatic logic hit(input logic cur_page, input logic [6:0] addr,
                                 input logic want_page, input logic [6:0] off);
        hit = (addr == off) && ((off == OFF_PAGE_SELECTOR) ||
                                (cur_page == want_page));
    endfunction

    logic wr_page, wr_byp, wr_dac, wr_n2;

    always_comb
    begin
        wr_page = reg_wr_en_in &&
                  hit(st.page, reg_addr_in, PAGE_ZERO, OFF_PAGE_SELECTOR);
        wr_byp = reg_wr_en_in &&
                 hit(st.page, reg_addr_in, PAGE_ZERO, OFF_BYPASS_SELECT);
        wr_dac = reg_wr_en_in &&
                 hit(st.page, reg_addr_in, PAGE_ZERO, OFF_DAC_CURRENT);
        wr_n2 = reg_wr_en_in &&
                hit(st.page, reg_addr_in, PAGE_ONE, OFF_N2_HIGH);
    end

    assign n0_if.wdata = reg_wdata_in;
    assign n1_if.wdata = reg_wdata_in;
    assign n0_if.wr_high = reg_wr_en_in &&
        hit(st.page, reg_addr_in, PAGE_ONE, OFF_N0_HIGH);
    assign n0_if.wr_low = reg_wr_en_in &&
        hit(st.page, reg_addr_in, PAGE_ONE, OFF_N0_LOW);
    assign n1_if.wr_high = reg_wr_en_in &&
        hit(st.page, reg_addr_in, PAGE_ONE, OFF_N1_HIGH);
    assign n1_if.wr_low = reg_wr_en_in &&
        hit(st.page, reg_addr_in, PAGE_ONE, OFF_N1_LOW);

    // ----------------------------------------
    // Coefficient pairs
    // ----------------------------------------
    cbpc_coef_pair #(.RST_HIGH(RST_N0_HIGH), .RST_LOW(RST_N0_LOW)) u_n0 (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .cif(n0_if.pair)
    );

    cbpc_coef_pair #(.RST_HIGH(RST_N1_HIGH), .RST_LOW(RST_N1_LOW)) u_n1 (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .cif(n1_if.pair)
    );

    // ----------------------------------------
    // Next state and read mux
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        // Upper page bits are not stored, so they always read back zero
        if (wr_page)
        begin
            next_st.page = reg_wdata_in[PAGE_BIT];
        end
        if (wr_byp)
        begin
            next_st.bypass = reg_wdata_in;
        end
        // Reserved code would over-drive the reference; keep the old code
        if (wr_dac && (reg_wdata_in[7:6] != DAC_CUR_RESERVED))
        begin
            next_st.dac_cur = reg_wdata_in[7:6];
        end
        if (wr_n2)
        begin
            next_st.n2_high = reg_wdata_in;
        end
        // Writes into the page-zero tail fall through every decode
        next_st.rvalid = reg_rd_en_in;
        next_st.rdata = RD_ZERO;
        if (reg_rd_en_in)
        begin
            if (reg_addr_in == OFF_PAGE_SELECTOR)
            begin
                next_st.rdata = {7'h00, st.page};
            end
            else if (st.page == PAGE_ZERO)
            begin
                if (reg_addr_in == OFF_BYPASS_SELECT)
                begin
                    next_st.rdata = st.bypass;
                end
                else if (reg_addr_in == OFF_DAC_CURRENT)
                begin
                    next_st.rdata = {st.dac_cur, 6'h00};
                end
            end
            else
            begin
                unique case (reg_addr_in)
                    OFF_N0_HIGH: next_st.rdata = n0_if.high_byte;
                    OFF_N0_LOW: next_st.rdata = n0_if.low_byte;
                    OFF_N1_HIGH: next_st.rdata = n1_if.high_byte;
                    OFF_N1_LOW: next_st.rdata = n1_if.low_byte;
                    OFF_N2_HIGH: next_st.rdata = st.n2_high;
                    default: next_st.rdata = RD_ZERO;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            st <= '{page: PAGE_ZERO, bypass: RST_BYPASS, dac_cur: RST_DAC_CUR,
                    n2_high: RST_N2_HIGH, rdata: RD_ZERO, rvalid: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_out = st.rdata;
    assign reg_rvalid_out = st.rvalid;
    assign page_one_active_out = st.page;
    // Both inputs onto one lineout shorts them; software must prevent it
    assign right_second_input_minus_bypass_out = st.bypass[BYP_R2_MINUS];
    assign right_second_input_plus_bypass_out = st.bypass[BYP_R2_PLUS];
    assign right_first_input_minus_bypass_out = st.bypass[BYP_R1_MINUS];
    assign right_first_input_plus_bypass_out = st.bypass[BYP_R1_PLUS];
    assign left_second_input_minus_bypass_out = st.bypass[BYP_L2_MINUS];
    assign left_second_input_plus_bypass_out = st.bypass[BYP_L2_PLUS];
    assign left_first_input_minus_bypass_out = st.bypass[BYP_L1_MINUS];
    assign left_first_input_plus_bypass_out = st.bypass[BYP_L1_PLUS];
    assign dac_current_out = st.dac_cur;
    assign fx_numerator_zero_out = n0_if.coef;
    assign fx_numerator_one_out = n1_if.coef;
    assign fx_numerator_two_high_out = st.n2_high;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence page_write_s(logic [7:0] d);
        reg_wr_en_in && reg_addr_in == OFF_PAGE_SELECTOR && reg_wdata_in == d;
    endsequence

    page_select_a: assert property (
        reg_wr_en_in && reg_addr_in == OFF_PAGE_SELECTOR
        |=> page_one_active_out == $past(reg_wdata_in[0]))
        else $error("page bit did not follow register zero write");

    page_readback_a: assert property (
        page_write_s(8'h01) ##2 (reg_rd_en_in && reg_addr_in == 7'h00)
        |=> reg_rvalid_out && reg_rdata_out == 8'h01)
        else $error("page bit readback wrong or upper bits not zero");

    bypass_write_a: assert property (
        reg_wr_en_in && !page_one_active_out && reg_addr_in == 7'h6c
        |=> right_first_input_minus_bypass_out == $past(reg_wdata_in[5])
            && left_first_input_plus_bypass_out == $past(reg_wdata_in[0]))
        else $error("bypass switch outputs did not follow write");

    bypass_hold_a: assert property (
        page_one_active_out && reg_wr_en_in && reg_addr_in == 7'h6c
        |=> $stable(st.bypass))
        else $error("bypass changed by a page one write");

    dac_reserved_a: assert property (
        reg_wr_en_in && !page_one_active_out && reg_addr_in == 7'h6d
        && reg_wdata_in[7:6] == 2'h2 |=> $stable(dac_current_out))
        else $error("reserved DAC current code was stored");

    dac_readback_a: assert property (
        reg_rd_en_in && !page_one_active_out && reg_addr_in == 7'h6d
        |=> reg_rdata_out[5:0] == 6'h00)
        else $error("DAC current low bits not zero");

    tail_read_zero_a: assert property (
        reg_rd_en_in && !page_one_active_out && reg_addr_in >= 7'h6e
        |=> reg_rvalid_out && reg_rdata_out == 8'h00)
        else $error("reserved tail returned nonzero");

    n2_write_a: assert property (
        reg_wr_en_in && page_one_active_out && reg_addr_in == 7'h05
        ##2 reg_rd_en_in && page_one_active_out && reg_addr_in == 7'h05
        |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("third numerator high byte readback wrong");

    read_latency_a: assert property (
        reg_rd_en_in |=> reg_rvalid_out ##1 !reg_rvalid_out || $past(reg_rd_en_in))
        else $error("read valid not one cycle after request");
endmodule // cbpc_regs
`default_nettype wire

//--- bench/cbpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbpc_host_model
    import cbpc_pkg::*;
(
    input wire logic clk_in,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] wdata_out,
    input wire logic [DATA_W-1:0] rdata_in,
    input wire logic rvalid_in
);
    initial
    begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = 7'h00;
        wdata_out = 8'h00;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Released lines show the inverse, so a stale value never passes
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d,
                      output bit ok);
        ok = 1'b0;
        d = 8'hxx;
        @(posedge clk_in);
        rd_en_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        addr_out <= ~a;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            #1;
            if (rvalid_in === 1'b1)
            begin
                d = rdata_in;
                ok = 1'b1;
            end
            else
                @(posedge clk_in);
        end
    endtask

    // High byte strictly first, low byte right after
    // Back to back on the bus, strobe held across both bytes
    task automatic wr_coef(input logic [6:0] hi, input logic [15:0] v);
        @(posedge clk_in);
        wr_en_out <= 1'b1;
        addr_out <= hi;
        wdata_out <= v[15:8];
        @(posedge clk_in);
        addr_out <= hi + 7'h01;
        wdata_out <= v[7:0];
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        addr_out <= ~(hi + 7'h01);
        wdata_out <= ~v[7:0];
    endtask
endmodule // cbpc_host_model
`default_nettype wire

//--- bench/tb_codec_bypass_page_coeff_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_codec_bypass_page_coeff_regs;
    import cbpc_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wr_en, rd_en, rvalid, page1;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, n2h;
    wire logic [7:0] byp;
    logic [1:0] dac;
    logic signed [15:0] fx0, fx1;
    int errors = 0;
    int num_checks = 0;

    always #25 clk_in = ~clk_in;

    cbpc_host_model host (.clk_in(clk_in), .wr_en_out(wr_en),
        .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata),
        .rdata_in(rdata), .rvalid_in(rvalid));

    cbpc_regs uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .page_one_active_out(page1),
        .right_second_input_minus_bypass_out(byp[7]),
        .right_second_input_plus_bypass_out(byp[6]),
        .right_first_input_minus_bypass_out(byp[5]),
        .right_first_input_plus_bypass_out(byp[4]),
        .left_second_input_minus_bypass_out(byp[3]),
        .left_second_input_plus_bypass_out(byp[2]),
        .left_first_input_minus_bypass_out(byp[1]),
        .left_first_input_plus_bypass_out(byp[0]),
        .dac_current_out(dac), .fx_numerator_zero_out(fx0),
        .fx_numerator_one_out(fx1), .fx_numerator_two_high_out(n2h));

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        host.rd(a, d, ok);
        if (!ok)
        begin
            errors++;
            print_verdict();
        end
        else
            chk({8'h00, d}, {8'h00, exp});
    endtask

    task automatic set_page(input logic p);
        host.wr(OFF_PAGE_SELECTOR, {7'h00, p});
        rdc(OFF_PAGE_SELECTOR, {7'h00, p});
        chk({15'h0000, page1}, {15'h0000, p});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] rv [5] = '{8'h6b, 8'he3, 8'h96, 8'h66, 8'h67};
        rdc(OFF_PAGE_SELECTOR, 8'h00);
        rdc(OFF_BYPASS_SELECT, 8'h00);
        rdc(OFF_DAC_CURRENT, 8'h00);
        chk(fx0, 16'h6be3);
        chk(fx1, 16'h9666);
        chk({8'h00, n2h}, 16'h0067);
        set_page(1'b1);
        for (int i = 0; i < 5; i++)
            rdc(7'(i + 1), rv[i]);
    endtask

    // One switch at a time, never two inputs onto one output
    task automatic t_bypass();
        for (int i = 0; i < 8; i++)
        begin
            host.wr(OFF_BYPASS_SELECT, 8'h01 << i);
            #1;
            chk({8'h00, byp}, 16'h0001 << i);
            rdc(OFF_BYPASS_SELECT, 8'h01 << i);
        end
    endtask

    task automatic t_dac();
        logic [1:0] codes [3] = '{2'h1, 2'h3, 2'h0};
        for (int i = 0; i < 3; i++)
        begin
            host.wr(OFF_DAC_CURRENT, {codes[i], 6'h00});
            #1;
            chk({14'h0000, dac}, {14'h0000, codes[i]});
            rdc(OFF_DAC_CURRENT, {codes[i], 6'h00});
        end
        host.wr(OFF_DAC_CURRENT, 8'hc0);
        // Reserved code written on purpose; field must hold
        host.wr(OFF_DAC_CURRENT, {DAC_CUR_RESERVED, 6'h00});
        #1;
        chk({14'h0000, dac}, 16'h0003);
        rdc(OFF_DAC_CURRENT, 8'hc0);
        host.wr(OFF_DAC_CURRENT, 8'h00);
    endtask

    task automatic t_reserved();
        host.wr(OFF_RSVD_TAIL_FIRST, 8'hff);
        host.wr(OFF_RSVD_TAIL_LAST, 8'hff);
        for (int a = 'h6e; a <= 'h7f; a++)
            rdc(7'(a), 8'h00);
    endtask

    task automatic t_coef();
        host.wr(OFF_BYPASS_SELECT, 8'h11);
        set_page(1'b1);
        // Page-zero address must miss while page one is active
        host.wr(OFF_BYPASS_SELECT, 8'hff);
        rdc(OFF_BYPASS_SELECT, 8'h00);
        chk({8'h00, byp}, 16'h0011);
        host.wr(OFF_N0_HIGH, 8'h80);
        #1;
        chk(fx0, 16'h6be3);
        host.wr(OFF_N0_LOW, 8'h01);
        #1;
        chk(fx0, 16'h8001);
        chk({15'h0000, fx0 < 0}, 16'h0001);
        host.wr_coef(OFF_N1_HIGH, 16'h7fff);
        #1;
        chk(fx1, 16'h7fff);
        host.wr(OFF_N2_HIGH, 8'h12);
        #1;
        chk({8'h00, n2h}, 16'h0012);
        rdc(OFF_N2_HIGH, 8'h12);
        rdc(OFF_N0_HIGH, 8'h80);
        rdc(OFF_N0_LOW, 8'h01);
        set_page(1'b0);
        rdc(OFF_BYPASS_SELECT, 8'h11);
    endtask

    // Reset in mid-run must reload every written register
    task automatic t_midreset();
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
    endtask

    initial
    begin
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        set_page(1'b0);
        t_bypass();
        t_dac();
        t_reserved();
        t_coef();
        t_midreset();
        print_verdict();
    end
endmodule // tb_codec_bypass_page_coeff_regs
`default_nettype wire
